// ===== src/swm_config_top.sv
// Link check and global configuration register bank behind the serial link
//
// Summary of operation
// - Link check read returns fixed pattern next frame
// - Link check reply lacks flags, clears nothing
// - Frame: address, read/write bit, 24 data bits
// - Config reply: fault bit 23, flag bit 22
// - Overvoltage, protection on: cap current, block sleep
// - Protection disabled: normal operation during overvoltage
// - Overvoltage flag sets regardless of disable bit
// - Qualify off: ignore wake pin when rail low
// - Qualify on: wake on any falling edge while in low power state
// - Interrupt style bit: pulse low or latch low
// - Mux method field selects channel control source
// - Bit per input: battery or ground switch
// - Closed switch always reported as one
// - Poll bit selects 1 ms or 55 us
// - Bits 21 to 14 read zero
`timescale 1ns/1ps
module swm_config_top #(
  parameter int unsigned POLL_SLOW_CYC = swm_pkg::POLL_SLOW_CYC,
  parameter int unsigned POLL_FAST_CYC = swm_pkg::POLL_FAST_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic fault_summary,
  input wire logic interrupt_flag,
  output logic flags_reported,
  input wire logic battery_supply_overvolt,
  input wire logic overvoltage_flag_clear,
  output logic overvoltage_flag,
  output logic wetting_cap_2ma,
  output logic low_power_entry_allowed,
  input wire logic wake_pin_n,
  input wire logic io_supply_rail_ok,
  input wire logic in_low_power_state,
  output logic wake_request,
  input wire logic [7:0] programmable_input_high,
  output logic [7:0] programmable_input_closed,
  output logic [7:0] switch_to_battery,
  output logic analog_channel_mux_by_spi,
  output logic analog_channel_mux_hw_two,
  output logic analog_channel_mux_hw_three,
  output logic battery_switch_poll_period,
  output logic battery_switch_poll_tick,
  input wire logic irq_event,
  input wire logic irq_release,
  output logic irq_pin_n
);
  typedef struct packed {
    logic [4:0] bit_cnt;
    logic [30:0] shift;
    logic [31:0] word;
    logic tog;
  } swm_link_state_t;

  typedef struct packed {
    logic [2:0] tog_sync;
    logic [31:0] reply;
    logic [13:0] cfg;
    logic [1:0] ovr_sync;
    logic ovr_flag;
    logic cap;
    logic lpm_ok;
    logic [2:0] wake_sync;
    logic [1:0] io_sync;
    logic wake_req;
    logic [7:0] lvl_s1;
    logic [7:0] lvl_s2;
    logic [7:0] closed;
    logic flags_rd;
  } swm_core_state_t;

  // Reply word: fault bit, flag bit, 22 data bits
  function automatic logic [31:0] reply_word(input logic fault, input logic flag,
                                             input logic [21:0] data);
    reply_word = {8'h00, fault, flag, data};
  endfunction : reply_word

  // One-hot {spi, hw two, hw three} from the method field
  function automatic logic [2:0] mux_method(input logic [1:0] sel);
    mux_method = 3'h4;
    if (sel == swm_pkg::MUX_HW_TWO) begin
      mux_method = 3'h2;
    end else if (sel == swm_pkg::MUX_HW_THREE) begin
      mux_method = 3'h1;
    end
  endfunction : mux_method

  swm_link_state_t l_q;
  swm_link_state_t l_d;
  swm_core_state_t c_q;
  swm_core_state_t c_d;
  logic fresh_q;
  logic frame_gap;
  logic [4:0] link_idx;
  logic take;
  logic [6:0] cmd_addr;
  logic cmd_wr;
  logic [23:0] cmd_data;
  logic [13:0] cmd_cfg;
  logic ovr_now;
  logic ovr_dis;
  logic wake_fall;
  logic [2:0] mux_sel;

  // Link side: frame start marker set while chip select is high
  assign frame_gap = spi_cs_n | sys_rst;
  always_ff @(posedge spi_sclk or posedge frame_gap) begin
    if (frame_gap) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  assign link_idx = fresh_q ? 5'h00 : l_q.bit_cnt;

  always_comb begin
    l_d = l_q;
    l_d.shift = {l_q.shift[29:0], spi_mosi};
    l_d.bit_cnt = link_idx + 5'h01;
    if (link_idx == 5'(swm_pkg::FRAME_BITS - 1)) begin
      l_d.word = {l_q.shift, spi_mosi};
      l_d.tog = ~l_q.tog;
    end
  end

  always_ff @(posedge spi_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Reply is static between frames; shifted out MSB first
  assign spi_miso = spi_cs_n ? 1'b0 : c_q.reply[~link_idx];
  assign spi_miso_oe = ~spi_cs_n;

  // Core side
  assign take = c_q.tog_sync[1] ^ c_q.tog_sync[2];
  assign cmd_addr = l_q.word[swm_pkg::ADDR_MSB:swm_pkg::ADDR_LSB];
  assign cmd_wr = l_q.word[swm_pkg::RW_BIT];
  assign cmd_data = l_q.word[swm_pkg::DATA_W-1:0];
  assign cmd_cfg = cmd_data[swm_pkg::CFG_W-1:0];
  assign ovr_now = c_q.ovr_sync[1];
  assign ovr_dis = c_q.cfg[swm_pkg::CFG_OVR_DIS_BIT];
  assign wake_fall = c_q.wake_sync[2] & ~c_q.wake_sync[1];

  always_comb begin
    c_d = c_q;
    c_d.tog_sync = {c_q.tog_sync[1:0], l_q.tog};
    c_d.flags_rd = 1'b0;
    if (take) begin
      unique case (cmd_addr)
        swm_pkg::ADDR_LINK_CHECK: begin
          c_d.reply = {8'h00, swm_pkg::CHECK_PATTERN};
        end
        swm_pkg::ADDR_GLOBAL_CONFIG: begin
          if (cmd_wr) begin
            c_d.cfg = cmd_cfg;
          end
          c_d.reply = reply_word(fault_summary, interrupt_flag, {8'h00, c_d.cfg});
          c_d.flags_rd = 1'b1;
        end
        default: begin
          c_d.reply = reply_word(fault_summary, interrupt_flag, 22'h000000);
          c_d.flags_rd = 1'b1;
        end
      endcase
    end
    c_d.ovr_sync = {c_q.ovr_sync[0], battery_supply_overvolt};
    c_d.cap = ovr_now & ~ovr_dis;
    c_d.lpm_ok = ~(ovr_now & ~ovr_dis);
    c_d.ovr_flag = ovr_now | (c_q.ovr_flag & ~overvoltage_flag_clear);
    c_d.wake_sync = {c_q.wake_sync[1:0], wake_pin_n};
    c_d.io_sync = {c_q.io_sync[0], io_supply_rail_ok};
    c_d.wake_req = wake_fall & in_low_power_state
                   & (c_q.cfg[swm_pkg::CFG_WAKE_QUAL_BIT] | c_q.io_sync[1]);
    c_d.lvl_s1 = programmable_input_high;
    c_d.lvl_s2 = c_q.lvl_s1;
    c_d.closed = ~(c_q.lvl_s2 ^ c_q.cfg[swm_pkg::PROG_IN_N-1:0]);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c_q <= '{cfg: swm_pkg::CFG_RESET, lpm_ok: 1'b1, wake_sync: 3'h7, default: '0};
    end else if (ce) begin
      c_q <= c_d;
    end
  end

  assign mux_sel = mux_method(c_q.cfg[swm_pkg::CFG_MUX_MSB:swm_pkg::CFG_MUX_LSB]);
  assign analog_channel_mux_by_spi = mux_sel[2];
  assign analog_channel_mux_hw_two = mux_sel[1];
  assign analog_channel_mux_hw_three = mux_sel[0];
  assign switch_to_battery = c_q.cfg[swm_pkg::PROG_IN_N-1:0];
  assign battery_switch_poll_period = c_q.cfg[swm_pkg::CFG_POLL_BIT];
  assign programmable_input_closed = c_q.closed;
  assign flags_reported = c_q.flags_rd;
  assign overvoltage_flag = c_q.ovr_flag;
  assign wetting_cap_2ma = c_q.cap;
  assign low_power_entry_allowed = c_q.lpm_ok;
  assign wake_request = c_q.wake_req;

  swm_ctl_if ctl ();
  assign ctl.poll_fast = c_q.cfg[swm_pkg::CFG_POLL_BIT];
  assign ctl.irq_pulse_mode = c_q.cfg[swm_pkg::CFG_IRQ_PULSE_BIT];
  assign ctl.irq_event = irq_event;
  assign ctl.irq_release = irq_release;
  assign battery_switch_poll_tick = ctl.poll_tick;
  assign irq_pin_n = ctl.irq_pin_n;

  swm_pin_ctl #(
    .POLL_SLOW_CYC(POLL_SLOW_CYC),
    .POLL_FAST_CYC(POLL_FAST_CYC)
  ) u_pins (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .ctl(ctl)
  );

  // Checks
  logic [7:0] lvl_now;
  logic [7:0] type_now;
  assign lvl_now = c_q.lvl_s2;
  assign type_now = c_q.cfg[7:0];

  sequence s_take(logic [6:0] a);
    take && cmd_addr == a;
  endsequence

  sequence s_ovr_protect;
    ovr_now && !ovr_dis;
  endsequence

  check_reply_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_take(swm_pkg::ADDR_LINK_CHECK) |=> c_q.reply == {8'h00, swm_pkg::CHECK_PATTERN})
    else $error("link check reply wrong");

  check_noflags_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_take(swm_pkg::ADDR_LINK_CHECK) |=> !flags_reported && c_q.reply[23:22] == 2'h0)
    else $error("link check touched flags");

  cfg_reply_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_take(swm_pkg::ADDR_GLOBAL_CONFIG) |=> c_q.reply[23] == $past(fault_summary)
      && c_q.reply[22] == $past(interrupt_flag) && c_q.reply[13:0] == c_q.cfg)
    else $error("config reply layout wrong");

  unused_zero_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_take(swm_pkg::ADDR_GLOBAL_CONFIG) |=> c_q.reply[21:14] == 8'h00
      && c_q.reply[31:24] == 8'h00)
    else $error("unused bits not zero");

  cfg_write_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_take(swm_pkg::ADDR_GLOBAL_CONFIG) ##0 cmd_wr |=> c_q.cfg == $past(cmd_cfg)
      && switch_to_battery == $past(cmd_data[7:0]))
    else $error("config write wrong");

  ovr_cap_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_ovr_protect |=> wetting_cap_2ma && !low_power_entry_allowed)
    else $error("overvoltage cap missing");

  ovr_free_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    ovr_dis |=> !wetting_cap_2ma && low_power_entry_allowed)
    else $error("disabled protection still acts");

  ovr_flag_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    ovr_now |=> overvoltage_flag [*2])
    else $error("overvoltage flag not set");

  wake_ignore_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    wake_fall && !c_q.cfg[11] && !c_q.io_sync[1] |=> !wake_request)
    else $error("wake taken with rail low");

  wake_go_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    wake_fall && c_q.cfg[11] && in_low_power_state |=> wake_request)
    else $error("wake edge missed");

  closed_map_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    1'b1 |=> programmable_input_closed == ~($past(lvl_now) ^ $past(type_now)))
    else $error("closed state mapping wrong");

  sequence s_take_other;
    take && cmd_addr != swm_pkg::ADDR_LINK_CHECK && cmd_addr != swm_pkg::ADDR_GLOBAL_CONFIG;
  endsequence

  other_write_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_take_other |=> c_q.cfg == $past(c_q.cfg) && c_q.reply[21:0] == 22'h000000)
    else $error("write to other address took effect");

  cfg_flags_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_take(swm_pkg::ADDR_GLOBAL_CONFIG) |=> flags_reported)
    else $error("config access did not report flags");

  mux_decode_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    c_q.cfg[swm_pkg::CFG_MUX_MSB] |-> !analog_channel_mux_by_spi
      && analog_channel_mux_hw_three == c_q.cfg[swm_pkg::CFG_MUX_LSB])
    else $error("mux method decode wrong");
endmodule : swm_config_top

// ===== src/swm_pkg.sv
// Constants and types shared by the switch monitor configuration block
package swm_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int FRAME_BITS = 32;
  localparam int ADDR_MSB = 31;
  localparam int ADDR_LSB = 25;
  localparam int RW_BIT = 24;
  localparam int DATA_W = 24;
  localparam logic [6:0] ADDR_LINK_CHECK = 7'h00;
  localparam logic [6:0] ADDR_GLOBAL_CONFIG = 7'h01;
  localparam logic [23:0] CHECK_PATTERN = 24'h123456;
  localparam int REPLY_FAULT_BIT = 23;
  localparam int REPLY_FLAG_BIT = 22;
  localparam int CFG_W = 14;
  localparam logic [13:0] CFG_RESET = 14'h08ff;
  localparam int CFG_POLL_BIT = 13;
  localparam int CFG_OVR_DIS_BIT = 12;
  localparam int CFG_WAKE_QUAL_BIT = 11;
  localparam int CFG_IRQ_PULSE_BIT = 10;
  localparam int CFG_MUX_MSB = 9;
  localparam int CFG_MUX_LSB = 8;
  localparam int PROG_IN_N = 8;
  localparam logic [1:0] MUX_HW_TWO = 2'h2;
  localparam logic [1:0] MUX_HW_THREE = 2'h3;
  localparam int unsigned POLL_SLOW_MS = 1;
  localparam int unsigned POLL_FAST_US = 55;
  localparam int unsigned POLL_SLOW_CYC = POLL_SLOW_MS * 1000 * CLK_MHZ;
  localparam int unsigned POLL_FAST_CYC = POLL_FAST_US * CLK_MHZ;
  localparam int POLL_CNT_W = 18;
  localparam int unsigned IRQ_PULSE_NS = 40;
  localparam int unsigned IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CNT_W = 4;
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_HELD = 2'b10
  } swm_irq_state_t;
endpackage : swm_pkg

// ===== src/swm_ctl_if.sv
// Control bundle between the configuration core and the pin timing module
`timescale 1ns/1ps
interface swm_ctl_if;
  logic poll_fast;
  logic irq_pulse_mode;
  logic irq_event;
  logic irq_release;
  logic irq_pin_n;
  logic poll_tick;
  modport core (
    output poll_fast,
    output irq_pulse_mode,
    output irq_event,
    output irq_release,
    input irq_pin_n,
    input poll_tick
  );
  modport pins (
    input poll_fast,
    input irq_pulse_mode,
    input irq_event,
    input irq_release,
    output irq_pin_n,
    output poll_tick
  );
endinterface : swm_ctl_if

// ===== src/swm_pin_ctl.sv
// Polling period timer and interrupt pin shaper
`timescale 1ns/1ps
module swm_pin_ctl #(
  parameter int unsigned POLL_SLOW_CYC = swm_pkg::POLL_SLOW_CYC,
  parameter int unsigned POLL_FAST_CYC = swm_pkg::POLL_FAST_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  swm_ctl_if.pins ctl
);
  typedef struct packed {
    logic [swm_pkg::POLL_CNT_W-1:0] poll_cnt;
    logic poll_tick;
    swm_pkg::swm_irq_state_t irq_st;
    logic [swm_pkg::PULSE_CNT_W-1:0] pulse_cnt;
  } swm_pin_state_t;

  swm_pin_state_t s_q;
  swm_pin_state_t s_d;
  logic [31:0] period_m1;

  always_comb begin
    s_d = s_q;
    s_d.poll_tick = 1'b0;
    period_m1 = ctl.poll_fast ? POLL_FAST_CYC - 1 : POLL_SLOW_CYC - 1;
    if (32'(s_q.poll_cnt) >= period_m1) begin
      s_d.poll_cnt = '0;
      s_d.poll_tick = 1'b1;
    end else begin
      s_d.poll_cnt = s_q.poll_cnt + 1'b1;
    end
    unique case (s_q.irq_st)
      swm_pkg::IRQ_IDLE: begin
        if (ctl.irq_event) begin
          s_d.irq_st = ctl.irq_pulse_mode ? swm_pkg::IRQ_PULSE : swm_pkg::IRQ_HELD;
          s_d.pulse_cnt = '0;
        end
      end
      swm_pkg::IRQ_PULSE: begin
        if (32'(s_q.pulse_cnt) >= swm_pkg::IRQ_PULSE_CYC - 1) begin
          s_d.irq_st = swm_pkg::IRQ_IDLE;
        end else begin
          s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
        end
      end
      swm_pkg::IRQ_HELD: begin
        if (ctl.irq_release && !ctl.irq_event) begin
          s_d.irq_st = swm_pkg::IRQ_IDLE;
        end
      end
      default: s_d.irq_st = swm_pkg::IRQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '{irq_st: swm_pkg::IRQ_IDLE, default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign ctl.poll_tick = s_q.poll_tick;
  assign ctl.irq_pin_n = (s_q.irq_st == swm_pkg::IRQ_IDLE);

  // Gap since previous tick, valid while the period select stays put
  logic [31:0] gap_q;
  logic gap_ok_q;
  logic fast_prev_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_q <= '0;
      gap_ok_q <= 1'b0;
      fast_prev_q <= 1'b0;
    end else if (ce) begin
      fast_prev_q <= ctl.poll_fast;
      gap_q <= s_q.poll_tick ? 32'h0 : gap_q + 32'h1;
      if (ctl.poll_fast != fast_prev_q) begin
        gap_ok_q <= 1'b0;
      end else if (s_q.poll_tick) begin
        gap_ok_q <= 1'b1;
      end
    end
  end

  sequence s_pulse_start;
    s_q.irq_st == swm_pkg::IRQ_IDLE && ctl.irq_event && ctl.irq_pulse_mode;
  endsequence

  irq_pulse_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_pulse_start |=> !ctl.irq_pin_n [*8] ##1 ctl.irq_pin_n)
    else $error("interrupt pulse width wrong");

  irq_latch_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_q.irq_st == swm_pkg::IRQ_HELD && !ctl.irq_release |=> !ctl.irq_pin_n)
    else $error("latched interrupt released early");

  poll_gap_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    s_q.poll_tick && gap_ok_q && ctl.poll_fast == fast_prev_q |-> gap_q == period_m1)
    else $error("poll period wrong");
endmodule : swm_pin_ctl

// ===== bench/swm_host_model.sv
// Host side serial master model for the configuration block
`timescale 1ns/1ps
module swm_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h1;
  end
  // One 32-bit frame, MSB first, 12 ns link clock only inside the frame
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    rsp = 32'h0;
    cs_n = 1'h0;
    #6;
    rsp[31] = miso;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #6 sclk = 1'h1;
      #6 sclk = 1'h0;
      if (i > 0) rsp[i-1] = miso;
    end
    #6 cs_n = 1'h1;
    // Released line shows the inverse of the last bit
    mosi = ~mosi;
    #60;
  endtask : xfer
endmodule : swm_host_model

// ===== bench/testbench.sv
// Self-checking bench for the switch monitor configuration block
`timescale 1ns/1ps
module testbench;
  logic clk, sys_rst, ce, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic fault_summary, interrupt_flag, flags_reported, battery_supply_overvolt;
  logic overvoltage_flag_clear, overvoltage_flag, wetting_cap_2ma, low_power_entry_allowed;
  logic wake_pin_n, io_supply_rail_ok, in_low_power_state, wake_request;
  logic [7:0] programmable_input_high, programmable_input_closed, switch_to_battery;
  logic analog_channel_mux_by_spi, analog_channel_mux_hw_two, analog_channel_mux_hw_three;
  logic battery_switch_poll_period, battery_switch_poll_tick, irq_event, irq_release, irq_pin_n;
  logic [31:0] rsp;
  int fails = 0;
  int num_checks = 0;
  int flags_n = 0;
  int wakes_n = 0;
  int cyc = 0;

  swm_config_top #(.POLL_SLOW_CYC(40), .POLL_FAST_CYC(12)) i_dut (
    .clk, .sys_rst, .ce, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
    .fault_summary, .interrupt_flag, .flags_reported, .battery_supply_overvolt,
    .overvoltage_flag_clear, .overvoltage_flag, .wetting_cap_2ma, .low_power_entry_allowed,
    .wake_pin_n, .io_supply_rail_ok, .in_low_power_state, .wake_request,
    .programmable_input_high, .programmable_input_closed, .switch_to_battery,
    .analog_channel_mux_by_spi, .analog_channel_mux_hw_two, .analog_channel_mux_hw_three,
    .battery_switch_poll_period, .battery_switch_poll_tick, .irq_event, .irq_release,
    .irq_pin_n
  );
  swm_host_model i_host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Event counters and hang limit
  always @(posedge clk) begin
    cyc++;
    if (flags_reported === 1'h1) flags_n++;
    if (wake_request === 1'h1) wakes_n++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] rep(input logic [13:0] c);
    return {8'h00, fault_summary, interrupt_flag, 8'h00, c};
  endfunction : rep

  task automatic frame(input logic [6:0] addr, input logic wr, input logic [23:0] data);
    i_host.xfer({addr, wr, data}, rsp);
    repeat (8) @(posedge clk);
  endtask : frame

  task automatic wr_cfg(input logic [23:0] data);
    frame(swm_pkg::ADDR_GLOBAL_CONFIG, 1'h1, data);
  endtask : wr_cfg

  // Config reply comes out during the following link check frame
  task automatic rd_cfg();
    frame(swm_pkg::ADDR_GLOBAL_CONFIG, 1'h0, 24'h0);
    frame(swm_pkg::ADDR_LINK_CHECK, 1'h0, 24'h0);
  endtask : rd_cfg

  task automatic t_reset();
    chk("battery types", 32'hff, {24'h0, switch_to_battery});
    chk("mux by spi", 32'h1, {31'h0, analog_channel_mux_by_spi});
    chk("poll period", 32'h0, {31'h0, battery_switch_poll_period});
    chk("miso idle", 32'h0, {30'h0, spi_miso_oe, spi_miso});
    rd_cfg();
    chk("cfg reset reply", rep(14'h08ff), rsp);
    $display("test reset done");
  endtask : t_reset

  task automatic t_check();
    int n;
    @(posedge clk);
    interrupt_flag <= 1'h1;
    n = flags_n;
    frame(swm_pkg::ADDR_LINK_CHECK, 1'h0, 24'h0);
    frame(swm_pkg::ADDR_LINK_CHECK, 1'h0, 24'h0);
    chk("check pattern", 32'h00123456, rsp);
    chk("flags kept", n, flags_n);
    rd_cfg();
    chk("cfg flags", rep(14'h08ff), rsp);
    chk("flags reported", n + 1, flags_n);
    $display("test link check done");
  endtask : t_check

  task automatic t_unused();
    wr_cfg(24'hffffff);
    rd_cfg();
    chk("unused bits", rep(14'h3fff), rsp);
    chk("unused ignored", 32'h0, {8'h0, rsp[21:14]});
    frame(7'h05, 1'h1, 24'h000000);
    frame(swm_pkg::ADDR_LINK_CHECK, 1'h0, 24'h0);
    chk("other address reply", rep(14'h0000), rsp);
    rd_cfg();
    chk("cfg kept", rep(14'h3fff), rsp);
    $display("test unused done");
  endtask : t_unused

  task automatic t_mux();
    logic [2:0] exp;
    for (int m = 0; m < 4; m++) begin
      wr_cfg({14'h0, m[1:0], 8'hff});
      exp = (m < 2) ? 3'h4 : (m == 2) ? 3'h2 : 3'h1;
      chk("mux method", {29'h0, exp}, {29'h0, analog_channel_mux_by_spi,
          analog_channel_mux_hw_two, analog_channel_mux_hw_three});
    end
    $display("test mux done");
  endtask : t_mux

  task automatic irq_lows(output int lows);
    lows = 0;
    @(posedge clk);
    irq_event <= 1'h1;
    @(posedge clk);
    irq_event <= 1'h0;
    repeat (14) begin
      #1 lows += (irq_pin_n === 1'h0);
      @(posedge clk);
    end
  endtask : irq_lows

  task automatic t_irq();
    int lows;
    wr_cfg(24'h000cff);
    irq_lows(lows);
    chk("pulse length", 32'h8, lows);
    wr_cfg(24'h0008ff);
    irq_lows(lows);
    chk("latched low", 32'h0, {31'h0, irq_pin_n});
    irq_release <= 1'h1;
    @(posedge clk);
    irq_release <= 1'h0;
    repeat (3) @(posedge clk);
    chk("latch released", 32'h1, {31'h0, irq_pin_n});
    $display("test interrupt pin done");
  endtask : t_irq

  task automatic t_ovr();
    wr_cfg(24'h0018ff);
    battery_supply_overvolt <= 1'h1;
    repeat (8) @(posedge clk);
    chk("ov flag disabled", 32'h1, {31'h0, overvoltage_flag});
    chk("no cap disabled", 32'h1, {30'h0, wetting_cap_2ma, low_power_entry_allowed});
    wr_cfg(24'h0008ff);
    chk("cap enabled", 32'h2, {30'h0, wetting_cap_2ma, low_power_entry_allowed});
    battery_supply_overvolt <= 1'h0;
    repeat (6) @(posedge clk);
    overvoltage_flag_clear <= 1'h1;
    @(posedge clk);
    overvoltage_flag_clear <= 1'h0;
    repeat (4) @(posedge clk);
    chk("ov flag cleared", 32'h0, {31'h0, overvoltage_flag});
    $display("test overvoltage done");
  endtask : t_ovr

  task automatic wake_edge();
    @(posedge clk);
    wake_pin_n <= 1'h0;
    repeat (10) @(posedge clk);
    wake_pin_n <= 1'h1;
    repeat (6) @(posedge clk);
  endtask : wake_edge

  task automatic t_wake();
    int n;
    n = wakes_n;
    in_low_power_state <= 1'h1;
    wr_cfg(24'h0000ff);
    wake_edge();
    chk("wake rail low", n, wakes_n);
    io_supply_rail_ok <= 1'h1;
    wake_edge();
    chk("wake rail ok", n + 1, wakes_n);
    io_supply_rail_ok <= 1'h0;
    wr_cfg(24'h0008ff);
    wake_edge();
    chk("wake qualified", n + 2, wakes_n);
    in_low_power_state <= 1'h0;
    $display("test wake done");
  endtask : t_wake

  task automatic t_types();
    wr_cfg(24'h00080f);
    programmable_input_high <= 8'h0f;
    repeat (6) @(posedge clk);
    chk("types", 32'h0f, {24'h0, switch_to_battery});
    chk("closed all", 32'hff, {24'h0, programmable_input_closed});
    programmable_input_high <= 8'hf0;
    repeat (6) @(posedge clk);
    chk("open all", 32'h0, {24'h0, programmable_input_closed});
    $display("test switch types done");
  endtask : t_types

  task automatic poll_gap(input int exp);
    int n;
    #1;
    n = 0;
    while (battery_switch_poll_tick !== 1'h1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (battery_switch_poll_tick !== 1'h1 && n < 100);
    chk("poll gap", exp, n);
  endtask : poll_gap

  task automatic t_poll();
    wr_cfg(24'h0028ff);
    chk("poll fast", 32'h1, {31'h0, battery_switch_poll_period});
    poll_gap(12);
    wr_cfg(24'h0008ff);
    poll_gap(40);
    $display("test polling done");
  endtask : t_poll

  initial begin
    sys_rst = 1'h1;
    ce = 1'h1;
    fault_summary = 1'h1;
    interrupt_flag = 1'h0;
    battery_supply_overvolt = 1'h0;
    overvoltage_flag_clear = 1'h0;
    wake_pin_n = 1'h1;
    io_supply_rail_ok = 1'h0;
    in_low_power_state = 1'h0;
    programmable_input_high = 8'h00;
    irq_event = 1'h0;
    irq_release = 1'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clk);
    t_reset();
    t_check();
    t_unused();
    t_mux();
    t_irq();
    t_ovr();
    t_wake();
    t_types();
    t_poll();
    stop_test();
  end
endmodule : testbench
